/* File: rtl/wdt_sleep_pkg.sv */
package wdt_sleep_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] OFF_PRESCALER_CTRL = 4'h0;
  localparam logic [3:0] OFF_FUSE_WORD      = 4'h4;
  localparam logic [3:0] OFF_STATUS         = 4'h8;
  localparam logic [3:0] OFF_COMMAND        = 4'hC;

  // Values after reset
  localparam logic [7:0]  PRESCALER_CTRL_RST = 8'hFF;
  localparam logic [31:0] READ_UNMAPPED      = 32'h0000_0000;

  // Field positions in timer_prescaler_control
  localparam int PSA_BIT = 3;
  localparam int PS_LSB  = 0;
  localparam int PS_W    = 3;

  // Field positions in device_fuse_word
  localparam int FUSE_WATCHDOG_ENABLE_FUSE_BIT = 3;
  localparam int FUSE_FOSC_LSB = 0;
  localparam int FUSE_FOSC_W   = 3;

  // Field positions in the status register
  localparam int STAT_TO_BIT    = 0;
  localparam int STAT_PD_BIT    = 1;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int STAT_OST_BIT   = 3;
  localparam int STAT_WATCHDOG_ENABLE_FUSE_BIT  = 4;

  // Field positions in the command register
  localparam int CMD_CLEAR_WATCHDOG_INSTR_BIT = 0;
  localparam int CMD_SLEEP_BIT  = 1;

  // Oscillator mode codes in the fuse word
  localparam logic [2:0] FOSC_CRYSTAL_LOW    = 3'h0;
  localparam logic [2:0] FOSC_CRYSTAL_MEDIUM = 3'h1;
  localparam logic [2:0] FOSC_CRYSTAL_HIGH   = 3'h2;
  localparam logic [2:0] FOSC_EXTERNAL_CLOCK = 3'h3;

  // Timing
  localparam int CLOCK_HZ        = 10_000_000;
  localparam int MAIN_OSC_HZ     = CLOCK_HZ;
  localparam int WDT_PERIOD_US   = 18_000;
  localparam int WDT_OSC_HZ_DEF  = 31_250;
  localparam int OST_OSC_PERIODS = 1024;
  localparam int OST_CYCLES      = (OST_OSC_PERIODS * (CLOCK_HZ / MAIN_OSC_HZ) < 1) ? 1
                                 : OST_OSC_PERIODS * (CLOCK_HZ / MAIN_OSC_HZ);
  localparam int WDT_BASE_TICKS_DEF = (WDT_OSC_HZ_DEF * WDT_PERIOD_US) / 1_000_000;

  // Widths and vector
  localparam int WDT_CNT_W   = 16;
  localparam int PRE_W       = 7;
  localparam int OST_CNT_W   = 11;
  localparam int IRQ_SRC_N   = 6;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // Power state machine
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_OST   = 3'b100
  } pm_state_t;

endpackage

/* File: rtl/watchdog_sleep_wake_control.sv */
`timescale 1ns/1ps
module watchdog_sleep_wake_control #(
  parameter int WDT_BASE_TICKS = wdt_sleep_pkg::WDT_BASE_TICKS_DEF
) (
  input  wire logic                              i_clock,
  input  wire logic                              i_sys_rst,
  input  wire logic [3:0]                        i_avs_address,
  input  wire logic                              i_avs_read,
  input  wire logic                              i_avs_write,
  input  wire logic [31:0]                       i_avs_writedata,
  input  wire logic [3:0]                        i_avs_byteenable,
  output logic      [31:0]                       o_avs_readdata,
  output logic                                   o_avs_waitrequest,
  input  wire logic [7:0]                        i_fuse_word,
  input  wire logic                              i_wdt_osc,
  input  wire logic                              i_master_clear_n,
  input  wire logic [wdt_sleep_pkg::IRQ_SRC_N-1:0] i_irq_flag,
  input  wire logic [wdt_sleep_pkg::IRQ_SRC_N-1:0] i_irq_enable,
  input  wire logic                              i_global_irq_enable,
  output logic                                   o_device_reset,
  output logic                                   o_sleeping,
  output logic                                   o_osc_driver_en,
  output logic                                   o_io_hold,
  output logic                                   o_prefetch_next,
  output logic                                   o_resume,
  output logic                                   o_vector_req,
  output logic      [12:0]                       o_vector_addr,
  output logic                                   o_timeout_status_flag,
  output logic                                   o_powerdown_status_flag
);

  // Ratio select to mask of prescaler bits that must all be one
  function automatic logic [wdt_sleep_pkg::PRE_W-1:0] ratio_mask(input logic [2:0] sel);
    logic [wdt_sleep_pkg::PRE_W:0] one_hot;
    one_hot = '0;
    one_hot[sel] = 1'b1;
    ratio_mask = one_hot[wdt_sleep_pkg::PRE_W-1:0] - 7'h01;
    if (sel == 3'h0) begin
      ratio_mask = 7'h00;
    end
  endfunction

  // Crystal-type oscillator modes need the start-up timer
  function automatic logic is_crystal_mode(input logic [2:0] fosc);
    is_crystal_mode = (fosc == wdt_sleep_pkg::FOSC_CRYSTAL_LOW) ||
                      (fosc == wdt_sleep_pkg::FOSC_CRYSTAL_MEDIUM) ||
                      (fosc == wdt_sleep_pkg::FOSC_CRYSTAL_HIGH);
  endfunction

  localparam logic [wdt_sleep_pkg::WDT_CNT_W-1:0] WDT_LAST = wdt_sleep_pkg::WDT_CNT_W'(WDT_BASE_TICKS - 1);
  localparam logic [wdt_sleep_pkg::OST_CNT_W-1:0] OST_LAST =
    wdt_sleep_pkg::OST_CNT_W'(wdt_sleep_pkg::OST_CYCLES - 1);

  wdt_sleep_pkg::pm_state_t state_q;
  wdt_sleep_pkg::pm_state_t state_d;
  logic [7:0]                             prescaler_ctrl_q;
  logic [wdt_sleep_pkg::WDT_CNT_W-1:0]    wdt_cnt_q;
  logic [wdt_sleep_pkg::PRE_W-1:0]        pre_cnt_q;
  logic [wdt_sleep_pkg::OST_CNT_W-1:0]    ost_cnt_q;
  logic [2:0]                             osc_sync_q;
  logic [1:0]                             master_clear_pin_sync_q;
  logic                                   wait_q;
  logic [31:0]                            readdata_q;
  logic                                   to_q;
  logic                                   pd_q;
  logic                                   reset_q;
  logic                                   osc_en_q;
  logic                                   io_hold_q;
  logic                                   sleeping_q;
  logic                                   prefetch_q;
  logic                                   resume_q;
  logic                                   vector_q;
  logic                                   wake_irq_q;

  logic       watchdog_enable_fuse;
  logic [2:0] fosc;
  logic       prescaler_assign_select;
  logic       osc_tick;
  logic       post_tick;
  logic       expire;
  logic       master_clear_pin_low;
  logic       rst_evt;
  logic       pending;
  logic       bus_take;
  logic       cmd_wr;
  logic       clear_watchdog_instr_cmd;
  logic       sleep_cmd;
  logic       sleep_go;
  logic       leave_sleep;
  logic       ost_done;
  logic       wdt_clear;

  // Decode of configuration and events
  assign watchdog_enable_fuse        = i_fuse_word[wdt_sleep_pkg::FUSE_WATCHDOG_ENABLE_FUSE_BIT];
  assign fosc        = i_fuse_word[wdt_sleep_pkg::FUSE_FOSC_LSB +: wdt_sleep_pkg::FUSE_FOSC_W];
  assign prescaler_assign_select         = prescaler_ctrl_q[wdt_sleep_pkg::PSA_BIT];
  assign osc_tick    = osc_sync_q[1] & ~osc_sync_q[2];
  assign post_tick   = osc_tick & (~prescaler_assign_select | ((pre_cnt_q & ratio_mask(prescaler_ctrl_q[2:0]))
                       == ratio_mask(prescaler_ctrl_q[2:0])));
  assign expire      = watchdog_enable_fuse & post_tick & (wdt_cnt_q == WDT_LAST);
  assign master_clear_pin_low    = ~master_clear_pin_sync_q[1];
  assign rst_evt     = master_clear_pin_low | (expire & (state_q == wdt_sleep_pkg::ST_RUN));
  assign pending     = |(i_irq_flag & i_irq_enable);
  assign bus_take    = (i_avs_read | i_avs_write) & ~wait_q;
  assign cmd_wr      = bus_take & i_avs_write & (i_avs_address == wdt_sleep_pkg::OFF_COMMAND) &
                       i_avs_byteenable[0];
  assign clear_watchdog_instr_cmd  = cmd_wr & i_avs_writedata[wdt_sleep_pkg::CMD_CLEAR_WATCHDOG_INSTR_BIT];
  assign sleep_cmd   = cmd_wr & i_avs_writedata[wdt_sleep_pkg::CMD_SLEEP_BIT] &
                       (state_q == wdt_sleep_pkg::ST_RUN) & ~rst_evt;
  assign sleep_go    = sleep_cmd & ~pending;
  assign leave_sleep = (state_q == wdt_sleep_pkg::ST_SLEEP) & ~master_clear_pin_low & (expire | pending);
  assign ost_done    = (state_q == wdt_sleep_pkg::ST_OST) & (ost_cnt_q == OST_LAST);
  assign wdt_clear   = ~watchdog_enable_fuse | clear_watchdog_instr_cmd | sleep_go | leave_sleep |
                       (state_q == wdt_sleep_pkg::ST_OST) | rst_evt;

  // Two-stage synchronisers for the watchdog oscillator and master clear
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      osc_sync_q  <= 3'h0;
      master_clear_pin_sync_q <= 2'h3;
    end else begin
      osc_sync_q  <= {osc_sync_q[1:0], i_wdt_osc};
      master_clear_pin_sync_q <= {master_clear_pin_sync_q[0], i_master_clear_n};
    end
  end

  // Avalon handshake: one wait cycle, read data captured before release
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wait_q     <= 1'b1;
      readdata_q <= wdt_sleep_pkg::READ_UNMAPPED;
    end else begin
      wait_q <= ~((i_avs_read | i_avs_write) & wait_q);
      if (i_avs_read && wait_q) begin
        case (i_avs_address)
          wdt_sleep_pkg::OFF_PRESCALER_CTRL: readdata_q <= {24'h000000, prescaler_ctrl_q};
          wdt_sleep_pkg::OFF_FUSE_WORD:      readdata_q <= {24'h000000, i_fuse_word};
          wdt_sleep_pkg::OFF_STATUS: begin
            readdata_q <= 32'h0000_0000;
            readdata_q[wdt_sleep_pkg::STAT_TO_BIT]    <= to_q;
            readdata_q[wdt_sleep_pkg::STAT_PD_BIT]    <= pd_q;
            readdata_q[wdt_sleep_pkg::STAT_SLEEP_BIT] <= state_q == wdt_sleep_pkg::ST_SLEEP;
            readdata_q[wdt_sleep_pkg::STAT_OST_BIT]   <= state_q == wdt_sleep_pkg::ST_OST;
            readdata_q[wdt_sleep_pkg::STAT_WATCHDOG_ENABLE_FUSE_BIT]  <= watchdog_enable_fuse;
          end
          default: readdata_q <= wdt_sleep_pkg::READ_UNMAPPED;
        endcase
      end
    end
  end

  // Timer control register, restored by every device reset
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prescaler_ctrl_q <= wdt_sleep_pkg::PRESCALER_CTRL_RST;
    end else if (rst_evt) begin
      prescaler_ctrl_q <= wdt_sleep_pkg::PRESCALER_CTRL_RST;
    end else if (bus_take && i_avs_write && i_avs_byteenable[0] &&
                 i_avs_address == wdt_sleep_pkg::OFF_PRESCALER_CTRL) begin
      prescaler_ctrl_q <= i_avs_writedata[7:0];
    end
  end

  // Prescaler, counting watchdog ticks only while assigned
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_cnt_q <= 7'h00;
    end else if (wdt_clear || !prescaler_assign_select) begin
      pre_cnt_q <= 7'h00;
    end else if (osc_tick) begin
      pre_cnt_q <= pre_cnt_q + 7'h01;
    end
  end

  // Watchdog counter on the postscaled tick
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wdt_cnt_q <= 16'h0000;
    end else if (wdt_clear) begin
      wdt_cnt_q <= 16'h0000;
    end else if (post_tick) begin
      wdt_cnt_q <= (wdt_cnt_q == WDT_LAST) ? 16'h0000 : wdt_cnt_q + 16'h0001;
    end
  end

  // Power state sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      wdt_sleep_pkg::ST_RUN: begin
        if (sleep_go) begin
          state_d = wdt_sleep_pkg::ST_SLEEP;
        end
      end
      wdt_sleep_pkg::ST_SLEEP: begin
        if (leave_sleep) begin
          state_d = is_crystal_mode(fosc) ? wdt_sleep_pkg::ST_OST : wdt_sleep_pkg::ST_RUN;
        end
      end
      wdt_sleep_pkg::ST_OST: begin
        if (ost_done) begin
          state_d = wdt_sleep_pkg::ST_RUN;
        end
      end
      default: state_d = wdt_sleep_pkg::ST_RUN;
    endcase
    if (rst_evt) begin
      state_d = wdt_sleep_pkg::ST_RUN;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= wdt_sleep_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Start-up timer counting main oscillator periods
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ost_cnt_q <= 11'h000;
    end else if (state_q == wdt_sleep_pkg::ST_OST) begin
      ost_cnt_q <= ost_cnt_q + 11'h001;
    end else begin
      ost_cnt_q <= 11'h000;
    end
  end

  // Status flags; a time-out in the same cycle wins over a clear-watchdog
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (expire) begin
      to_q <= 1'b0;
    end else if (sleep_go) begin
      to_q <= 1'b1;
      pd_q <= 1'b0;
    end else if (clear_watchdog_instr_cmd) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end
  end

  // Internal reset only; the master-clear pin is never driven
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      reset_q <= 1'b1;
    end else begin
      reset_q <= rst_evt;
    end
  end

  // Oscillator driver, pin hold and prefetch
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      osc_en_q   <= 1'b1;
      io_hold_q  <= 1'b0;
      sleeping_q <= 1'b0;
      prefetch_q <= 1'b0;
    end else begin
      osc_en_q   <= state_d != wdt_sleep_pkg::ST_SLEEP;
      io_hold_q  <= state_d != wdt_sleep_pkg::ST_RUN;
      sleeping_q <= state_d == wdt_sleep_pkg::ST_SLEEP;
      prefetch_q <= sleep_cmd;
    end
  end

  // Resume and vector requests after a non-reset wake
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wake_irq_q <= 1'b0;
      resume_q   <= 1'b0;
      vector_q   <= 1'b0;
    end else begin
      if (leave_sleep) begin
        wake_irq_q <= ~expire;
      end
      resume_q <= ~rst_evt & (state_q != wdt_sleep_pkg::ST_RUN) &
                  (state_d == wdt_sleep_pkg::ST_RUN);
      vector_q <= ~rst_evt & (state_q != wdt_sleep_pkg::ST_RUN) &
                  (state_d == wdt_sleep_pkg::ST_RUN) & i_global_irq_enable &
                  (leave_sleep ? ~expire : wake_irq_q);
    end
  end

  assign o_avs_readdata          = readdata_q;
  assign o_avs_waitrequest       = wait_q;
  assign o_device_reset          = reset_q;
  assign o_sleeping              = sleeping_q;
  assign o_osc_driver_en         = osc_en_q;
  assign o_io_hold               = io_hold_q;
  assign o_prefetch_next         = prefetch_q;
  assign o_resume                = resume_q;
  assign o_vector_req            = vector_q;
  assign o_vector_addr           = wdt_sleep_pkg::IRQ_VECTOR;
  assign o_timeout_status_flag   = to_q;
  assign o_powerdown_status_flag = pd_q;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence s_sleep_entry;
    sleep_go ##1 (state_q == wdt_sleep_pkg::ST_SLEEP);
  endsequence

  sequence s_irq_wake;
    (state_q == wdt_sleep_pkg::ST_SLEEP) && pending && !expire && !master_clear_pin_low;
  endsequence

  a_fuse_off_idle: assert property (!watchdog_enable_fuse |=> wdt_cnt_q == 16'h0000 && !expire)
    else $error("watchdog counts with fuse off");
  a_run_expiry_reset: assert property ((state_q == wdt_sleep_pkg::ST_RUN) && expire
    |=> o_device_reset && !o_timeout_status_flag && state_q == wdt_sleep_pkg::ST_RUN)
    else $error("expiry in run gave no reset");
  a_sleep_expiry_wake: assert property ((state_q == wdt_sleep_pkg::ST_SLEEP) && expire && !master_clear_pin_low
    |=> !o_device_reset && !o_timeout_status_flag && state_q != wdt_sleep_pkg::ST_SLEEP)
    else $error("expiry in sleep did not wake");
  a_sleep_entry_flags: assert property (s_sleep_entry |-> !pd_q && to_q && wdt_cnt_q == 16'h0000
    ##1 !o_osc_driver_en && o_io_hold)
    else $error("sleep entry effects missing");
  a_sleep_nop_case: assert property (sleep_cmd && pending
    |=> state_q == wdt_sleep_pkg::ST_RUN && $stable(pd_q) && o_prefetch_next)
    else $error("sleep with pending flag not a nop");
  a_ost_hold_clear: assert property ((state_q == wdt_sleep_pkg::ST_OST) |=> wdt_cnt_q == 16'h0000)
    else $error("watchdog ran during start-up");
  a_ost_length: assert property ((state_q == wdt_sleep_pkg::ST_OST) && ost_cnt_q == OST_LAST && !rst_evt
    |=> state_q == wdt_sleep_pkg::ST_RUN && o_resume)
    else $error("start-up timer length wrong");
  a_wake_clears_wdt: assert property (leave_sleep |=> wdt_cnt_q == 16'h0000)
    else $error("wake did not clear watchdog");
  a_irq_vector: assert property ((s_irq_wake and (!is_crystal_mode(fosc) && i_global_irq_enable))
    |=> o_resume && o_vector_req && o_timeout_status_flag)
    else $error("interrupt wake lacks vector request");
  a_clear_watchdog_instr_clears: assert property (clear_watchdog_instr_cmd && !expire |=> wdt_cnt_q == 16'h0000 && pre_cnt_q == 7'h00
    && to_q && pd_q)
    else $error("clear-watchdog did not clear");

endmodule

/* File: tb/tb_watchdog_sleep_wake_control.sv */
`timescale 1ns/1ps
module tb_watchdog_sleep_wake_control;
  logic        i_clock, i_sys_rst, i_avs_read, i_avs_write, i_wdt_osc, i_master_clear_n, i_global_irq_enable;
  logic [3:0]  i_avs_address, i_avs_byteenable;
  logic [31:0] i_avs_writedata, o_avs_readdata, rd;
  logic [7:0]  i_fuse_word;
  logic [5:0]  i_irq_flag, i_irq_enable;
  logic [12:0] o_vector_addr;
  logic        o_avs_waitrequest, o_device_reset, o_sleeping, o_osc_driver_en, o_io_hold;
  logic        o_prefetch_next, o_resume, o_vector_req, o_timeout_status_flag, o_powerdown_status_flag;
  logic [2:0]  osc_div;
  int          ev [4];
  int          fail_count, n_compared, cyc, base, vb;

  // Short base count keeps the 1:1 watchdog period at 32 clocks
  watchdog_sleep_wake_control #(.WDT_BASE_TICKS(4)) u_watchdog_sleep_wake_control (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_fuse_word(i_fuse_word),
    .i_wdt_osc(i_wdt_osc), .i_master_clear_n(i_master_clear_n), .i_irq_flag(i_irq_flag),
    .i_irq_enable(i_irq_enable), .i_global_irq_enable(i_global_irq_enable), .o_device_reset(o_device_reset),
    .o_sleeping(o_sleeping), .o_osc_driver_en(o_osc_driver_en), .o_io_hold(o_io_hold),
    .o_prefetch_next(o_prefetch_next), .o_resume(o_resume), .o_vector_req(o_vector_req),
    .o_vector_addr(o_vector_addr), .o_timeout_status_flag(o_timeout_status_flag),
    .o_powerdown_status_flag(o_powerdown_status_flag));

  // System clock
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // Watchdog oscillator of 8 clocks a tick; pulse counters for the design's events
  always @(posedge i_clock) begin
    osc_div <= osc_div + 3'h1;
    i_wdt_osc <= osc_div[2];
    if (!i_sys_rst) begin
      ev[0] <= ev[0] + (o_device_reset === 1'b1);
      ev[1] <= ev[1] + (o_resume === 1'b1);
      ev[2] <= ev[2] + (o_vector_req === 1'b1);
      ev[3] <= ev[3] + (o_prefetch_next === 1'b1);
    end
  end

  task automatic final_report();
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      final_report();
    end
  endtask

  // Waits for the next pulse of one event counter, bounded
  task automatic wait_ev(input int k, input int lim);
    int s;
    s = ev[k];
    cyc = 0;
    while (ev[k] == s && cyc < lim) begin
      @(posedge i_clock);
      cyc++;
    end
    if (ev[k] == s) begin
      fail_count++;
      final_report();
    end
  endtask

  // Main sequence
  initial begin
    i_sys_rst = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 4'h0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'hF;
    i_fuse_word = 8'h0B;
    i_master_clear_n = 1'b1;
    i_irq_flag = 6'h00;
    i_irq_enable = 6'h00;
    i_global_irq_enable = 1'b0;
    i_wdt_osc = 1'b0;
    osc_div = 3'h0;
    ev = '{default: 0};
    fail_count = 0;
    n_compared = 0;
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    // Reset values, read-only fuse word, unmapped place
    bus(0, 4'h0, 32'h0);
    check("prescaler_ctrl", rd, 32'h0000_00FF);
    bus(0, 4'h8, 32'h0);
    check("status", rd, 32'h0000_0013);
    bus(1, 4'h4, 32'h0);
    bus(0, 4'h4, 32'h0);
    check("fuse_word", rd, 32'h0000_000B);
    bus(0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h0);
    // Expiry in run for prescale ratios 1:1 to 1:8
    for (int r = 0; r < 4; r++) begin
      bus(1, 4'h0, 32'h8 + 32'(r));
      bus(1, 4'hC, 32'h1);
      wait_ev(0, 400);
      check("wdt_period", (cyc > (32 << r) - 12) && (cyc < (32 << r) + 16), 1);
      check("to_after_reset", o_timeout_status_flag, 0);
      bus(0, 4'h0, 32'h0);
      check("prescaler_ctrl_reset", rd, 32'h0000_00FF);
    end
    // Regular clearing keeps the watchdog from expiring
    bus(1, 4'h0, 32'h0);
    base = ev[0];
    repeat (12) begin
      bus(1, 4'hC, 32'h1);
      repeat (10) @(posedge i_clock);
    end
    check("no_reset_cleared", ev[0] - base, 0);
    // Sleep, then watchdog wake without reset
    base = ev[3];
    bus(1, 4'hC, 32'h2);
    repeat (2) @(posedge i_clock);
    check("prefetch", ev[3] - base, 1);
    check("osc_stopped", {o_sleeping, o_osc_driver_en, o_io_hold}, 3'b101);
    bus(0, 4'h8, 32'h0);
    check("status_sleep", rd, 32'h0000_0015);
    base = ev[0];
    wait_ev(1, 80);
    check("wake_no_reset", ev[0] - base, 0);
    check("to_on_wake", o_timeout_status_flag, 0);
    check("pd_on_wake", o_powerdown_status_flag, 0);
    wait_ev(0, 80);
    check("cleared_on_wake", cyc > 20, 1);
    // Interrupt wake in every oscillator mode, watchdog fused off
    base = ev[0];
    for (int i = 0; i < 8; i++) begin
      i_fuse_word <= 8'(i);
      i_global_irq_enable <= i[0];
      bus(1, 4'hC, 32'h2);
      i_irq_flag <= 6'h01 << (i % 6);
      repeat (40) @(posedge i_clock);
      check("masked_asleep", o_sleeping, 1);
      vb = ev[2];
      i_irq_enable <= 6'h3F;
      wait_ev(1, 1100);
      check("wake_latency", (i < 3) ? (cyc > 1023 && cyc < 1032) : (cyc < 6), 1);
      check("vector_req", ev[2] - vb, i[0]);
      i_irq_flag <= 6'h00;
      i_irq_enable <= 6'h00;
    end
    check("fused_off", ev[0] - base, 0);
    check("vector_addr", o_vector_addr, 13'h0004);
    // Sleep with an enabled flag pending degrades to no-operation
    i_fuse_word <= 8'h0B;
    bus(1, 4'hC, 32'h1);
    i_irq_flag <= 6'h04;
    i_irq_enable <= 6'h04;
    base = ev[3];
    bus(1, 4'hC, 32'h2);
    repeat (2) @(posedge i_clock);
    check("nop_prefetch", ev[3] - base, 1);
    check("nop_awake", o_sleeping, 0);
    check("nop_pd", o_powerdown_status_flag, 1);
    i_irq_flag <= 6'h00;
    i_irq_enable <= 6'h00;
    // Master clear wakes from sleep by reset
    bus(1, 4'hC, 32'h1);
    bus(1, 4'hC, 32'h2);
    base = ev[1];
    i_master_clear_n <= 1'b0;
    repeat (5) @(posedge i_clock);
    check("master_clear_pin_reset", o_device_reset, 1);
    check("master_clear_pin_no_resume", ev[1] - base, 0);
    i_master_clear_n <= 1'b1;
    repeat (5) @(posedge i_clock);
    final_report();
  end
endmodule
